// *** hw/umh_pkg.sv ***
package umh_pkg;

  // Bus geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int NUM_PORTS = 2;

  // Register map, byte addresses; port n sits at n * PORT_STRIDE
  localparam logic [ADDR_W-1:0] ADDR_CTL0 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_IER0 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STAT0 = 8'h08;
  localparam logic [ADDR_W-1:0] PORT_STRIDE = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_FUNC = 8'h18;

  // Modem control fields
  localparam int CTL_W = 5;
  localparam int CTL_DTR = 0;
  localparam int CTL_RTS = 1;
  localparam int CTL_OUT1 = 2;
  localparam int CTL_OUT2 = 3;
  localparam int CTL_LOOP = 4;
  localparam logic [CTL_W-1:0] CTL_RST = 5'h00;

  // Interrupt enable fields
  localparam int IER_W = 4;
  localparam int IER_MSI = 3;
  localparam logic [IER_W-1:0] IER_RST = 4'h0;

  // Modem status fields; low nibble change flags, high nibble line states
  localparam int STAT_W = 8;
  localparam int LINES = 4;
  localparam int STAT_DCTS = 0;
  localparam int STAT_DDSR = 1;
  localparam int STAT_TERI = 2;
  localparam int STAT_DDCD = 3;
  localparam int STAT_CTS = 4;
  localparam int STAT_DSR = 5;
  localparam int STAT_RI = 6;
  localparam int STAT_DCD = 7;
  localparam logic [LINES-1:0] LINES_IDLE = 4'hF;
  localparam logic [LINES-1:0] FLAGS_RST = 4'h0;

  // Secondary transmit function select
  localparam int FUNC_IR = 0;

  typedef logic [CTL_W-1:0] umh_ctl_t;
  typedef logic [IER_W-1:0] umh_ier_t;
  typedef logic [STAT_W-1:0] umh_stat_t;

endpackage

// *** hw/umh_port_if.sv ***
`timescale 1ns/10ps
interface umh_port_if;
  import umh_pkg::*;
  umh_ctl_t ctl;
  logic ier_msi;
  logic stat_rd;
  umh_stat_t stat;
  logic irq;
  modport ctl_side (output ctl, output ier_msi, output stat_rd, input stat, input irq);
  modport port (input ctl, input ier_msi, input stat_rd, output stat, output irq);
endinterface // umh_port_if

// *** hw/umh_port.sv ***
`timescale 1ns/10ps
module umh_port
  import umh_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register side
  umh_port_if.port bus,
  // Modem outputs
  output logic send_request_n,
  output logic terminal_ready_n,
  // Modem inputs
  input wire logic clear_to_transmit_n,
  input wire logic set_ready_n,
  input wire logic ring_n,
  input wire logic carrier_found_n
);

  logic [LINES-1:0] in_n;
  logic [LINES-1:0] lines_q;
  logic [LINES-1:0] lines_d;
  logic [LINES-1:0] delta_q;
  logic [LINES-1:0] delta_d;
  logic [LINES-1:0] chg_q;
  logic [LINES-1:0] chg_d;
  logic rts_n_q;
  logic rts_n_d;
  logic dtr_n_q;
  logic dtr_n_d;

  always_comb begin
    // Loopback feeds the control bits back in place of the pins
    if (bus.ctl[CTL_LOOP]) begin
      in_n = ~{bus.ctl[CTL_OUT2], bus.ctl[CTL_OUT1], bus.ctl[CTL_DTR], bus.ctl[CTL_RTS]};
    end else begin
      in_n = {carrier_found_n, ring_n, set_ready_n, clear_to_transmit_n};
    end
    lines_d = in_n;
    // New edges are ORed in after the clear, so a read never drops one
    delta_d = (bus.stat_rd ? FLAGS_RST : delta_q) | (~lines_q & in_n);
    chg_d = (bus.stat_rd ? FLAGS_RST : chg_q) | (lines_q ^ in_n);
    rts_n_d = ~(bus.ctl[CTL_RTS] & ~bus.ctl[CTL_LOOP]);
    dtr_n_d = ~(bus.ctl[CTL_DTR] & ~bus.ctl[CTL_LOOP]);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lines_q <= LINES_IDLE;
      delta_q <= FLAGS_RST;
      chg_q <= FLAGS_RST;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
    end else begin
      lines_q <= lines_d;
      delta_q <= delta_d;
      chg_q <= chg_d;
      rts_n_q <= rts_n_d;
      dtr_n_q <= dtr_n_d;
    end
  end

  // Line states read inverted: a low pin shows as one
  assign bus.stat = {~lines_q, delta_q};
  assign bus.irq = bus.ier_msi & (|chg_q);
  assign send_request_n = rts_n_q;
  assign terminal_ready_n = dtr_n_q;

endmodule // umh_port

// *** hw/umh_top.sv ***
`timescale 1ns/10ps
module umh_top
  import umh_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Primary modem lines
  output logic primary_send_request_n,
  output logic primary_terminal_ready_n,
  input wire logic primary_clear_to_transmit_n,
  input wire logic primary_set_ready_n,
  input wire logic primary_ring_n,
  input wire logic primary_carrier_found_n,
  output logic primary_irq,
  // Secondary modem lines
  output logic secondary_send_request_n,
  output logic secondary_terminal_ready_n,
  input wire logic secondary_clear_to_transmit_n,
  input wire logic secondary_set_ready_n,
  input wire logic secondary_ring_n,
  input wire logic secondary_carrier_found_n,
  output logic secondary_irq,
  // Secondary transmit sources and pin
  input wire logic sec_uart_tx,
  input wire logic sec_ir_encoded,
  output logic secondary_serial_out
);

  function automatic logic [ADDR_W-1:0] port_addr(input int idx, input logic [ADDR_W-1:0] off);
    logic [ADDR_W-1:0] base;
    base = ADDR_W'(idx) * PORT_STRIDE;
    return off + base;
  endfunction

  umh_ctl_t ctl_q [NUM_PORTS];
  umh_ctl_t ctl_d [NUM_PORTS];
  umh_ier_t ier_q [NUM_PORTS];
  umh_ier_t ier_d [NUM_PORTS];
  umh_stat_t stat_v [NUM_PORTS];
  logic ir_sel_q;
  logic ir_sel_d;
  logic txo_q;
  logic txo_d;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic [DATA_W-1:0] rd_mux;
  logic setup;
  logic acc;
  logic wr_acc;
  logic hit_func;
  logic mapped;
  logic [NUM_PORTS-1:0] hit_ctl;
  logic [NUM_PORTS-1:0] hit_ier;
  logic [NUM_PORTS-1:0] hit_stat;
  logic [NUM_PORTS-1:0] stat_rd;
  logic [NUM_PORTS-1:0] rts_n;
  logic [NUM_PORTS-1:0] dtr_n;
  logic [NUM_PORTS-1:0] cts_n;
  logic [NUM_PORTS-1:0] dsr_n;
  logic [NUM_PORTS-1:0] ri_n;
  logic [NUM_PORTS-1:0] dcd_n;
  logic [NUM_PORTS-1:0] irq;

  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign wr_acc = acc & pwrite;

  always_comb begin
    hit_func = (paddr == ADDR_FUNC);
    for (int i = 0; i < NUM_PORTS; i++) begin
      hit_ctl[i] = (paddr == port_addr(i, ADDR_CTL0));
      hit_ier[i] = (paddr == port_addr(i, ADDR_IER0));
      hit_stat[i] = (paddr == port_addr(i, ADDR_STAT0));
    end
    mapped = hit_func | (|hit_ctl) | (|hit_ier) | (|hit_stat);
  end

  always_comb begin
    rd_mux = '0;
    if (hit_func) begin
      rd_mux[FUNC_IR] = ir_sel_q;
    end
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (hit_ctl[i]) begin
        rd_mux[CTL_W-1:0] = ctl_q[i];
      end
      if (hit_ier[i]) begin
        rd_mux[IER_W-1:0] = ier_q[i];
      end
      if (hit_stat[i]) begin
        rd_mux[STAT_W-1:0] = stat_v[i];
      end
    end
  end

  // Status read clears at the setup edge, the same edge that snapshots it,
  // so an edge landing there is both reported later and never lost.
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      stat_rd[i] = setup & ~pwrite & hit_stat[i];
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      ctl_d[i] = ctl_q[i];
      ier_d[i] = ier_q[i];
      if (wr_acc && hit_ctl[i]) begin
        ctl_d[i] = pwdata[CTL_W-1:0];
      end
      if (wr_acc && hit_ier[i]) begin
        ier_d[i] = pwdata[IER_W-1:0];
      end
    end
    ir_sel_d = ir_sel_q;
    if (wr_acc && hit_func) begin
      ir_sel_d = pwdata[FUNC_IR];
    end
    prdata_d = prdata_q;
    if (setup && !pwrite) begin
      prdata_d = rd_mux;
    end
    // No clear-to-transmit term anywhere on this path
    txo_d = ir_sel_q ? sec_ir_encoded : sec_uart_tx;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        ctl_q[i] <= CTL_RST;
        ier_q[i] <= IER_RST;
      end
      ir_sel_q <= 1'b0;
      txo_q <= 1'b1;
      prdata_q <= '0;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        ctl_q[i] <= ctl_d[i];
        ier_q[i] <= ier_d[i];
      end
      ir_sel_q <= ir_sel_d;
      txo_q <= txo_d;
      prdata_q <= prdata_d;
    end
  end

  // Zero wait states; errors only for unmapped or misaligned words
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  assign cts_n = {secondary_clear_to_transmit_n, primary_clear_to_transmit_n};
  assign dsr_n = {secondary_set_ready_n, primary_set_ready_n};
  assign ri_n = {secondary_ring_n, primary_ring_n};
  assign dcd_n = {secondary_carrier_found_n, primary_carrier_found_n};

  umh_port_if pif [NUM_PORTS] ();

  // One private instance per port keeps their state apart
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    assign pif[g].ctl = ctl_q[g];
    assign pif[g].ier_msi = ier_q[g][IER_MSI];
    assign pif[g].stat_rd = stat_rd[g];
    assign stat_v[g] = pif[g].stat;
    assign irq[g] = pif[g].irq;
    umh_port u_port (
      .clock(clock),
      .rstn(rstn),
      .bus(pif[g]),
      .send_request_n(rts_n[g]),
      .terminal_ready_n(dtr_n[g]),
      .clear_to_transmit_n(cts_n[g]),
      .set_ready_n(dsr_n[g]),
      .ring_n(ri_n[g]),
      .carrier_found_n(dcd_n[g])
    );
  end

  assign primary_send_request_n = rts_n[0];
  assign primary_terminal_ready_n = dtr_n[0];
  assign secondary_send_request_n = rts_n[1];
  assign secondary_terminal_ready_n = dtr_n[1];
  assign primary_irq = irq[0];
  assign secondary_irq = irq[1];
  assign secondary_serial_out = txo_q;

  // Checks
  logic loop0;
  logic loop1;
  logic rd_stat0;
  logic wr_ctl0;
  logic wr_ctl1;
  assign loop0 = ctl_q[0][CTL_LOOP];
  assign loop1 = ctl_q[1][CTL_LOOP];
  assign rd_stat0 = setup & ~pwrite & hit_stat[0];
  assign wr_ctl0 = wr_acc & hit_ctl[0];
  assign wr_ctl1 = wr_acc & hit_ctl[1];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  property p_rts_follow;
    wr_ctl0 && pwdata[CTL_RTS] && !pwdata[CTL_LOOP] |=> ##1 !primary_send_request_n;
  endproperty
  a_rts_follow: assert property (p_rts_follow)
    else $error("primary send request not driven low after control write");

  property p_dtr_follow;
    wr_ctl1 && !pwdata[CTL_DTR] |=> ##1 secondary_terminal_ready_n;
  endproperty
  a_dtr_follow: assert property (p_dtr_follow)
    else $error("secondary terminal ready not released after control write");

  property p_reset_rts;
    !$past(rstn) |-> primary_send_request_n && secondary_send_request_n;
  endproperty
  a_reset_rts: assert property (p_reset_rts)
    else $error("send request not high after reset");

  property p_reset_dtr;
    !$past(rstn) |-> primary_terminal_ready_n && secondary_terminal_ready_n;
  endproperty
  a_reset_dtr: assert property (p_reset_dtr)
    else $error("terminal ready not high after reset");

  property p_loop_quiet;
    loop0 && $past(loop0) |-> primary_send_request_n && primary_terminal_ready_n;
  endproperty
  a_loop_quiet: assert property (p_loop_quiet)
    else $error("handshake pins active during loopback");

  property p_cts_status;
    rd_stat0 && !loop0 && !$past(loop0) |=> prdata[STAT_CTS] == !$past(primary_clear_to_transmit_n, 2);
  endproperty
  a_cts_status: assert property (p_cts_status)
    else $error("status read does not show inverted clear-to-transmit");

  property p_cts_delta;
    !loop0 && !$past(loop0) && $rose(primary_clear_to_transmit_n) |=> stat_v[0][STAT_DCTS];
  endproperty
  a_cts_delta: assert property (p_cts_delta)
    else $error("clear-to-transmit rise did not set its change flag");

  property p_dcd_delta;
    !loop1 && !$past(loop1) && $rose(secondary_carrier_found_n) |=> stat_v[1][STAT_DDCD];
  endproperty
  a_dcd_delta: assert property (p_dcd_delta)
    else $error("carrier rise did not set its change flag");

  property p_ring_delta;
    !loop0 && !$past(loop0) && $rose(primary_ring_n) |=> stat_v[0][STAT_TERI] && !stat_v[0][STAT_RI];
  endproperty
  a_ring_delta: assert property (p_ring_delta)
    else $error("ring rise did not set its change flag");

  property p_stat_irq;
    ier_q[0][IER_MSI] && !wr_acc && !loop0 && !$past(loop0) && $changed(primary_set_ready_n)
      |=> primary_irq;
  endproperty
  a_stat_irq: assert property (p_stat_irq)
    else $error("modem input change did not raise the interrupt");

  property p_stat_clear;
    rd_stat0 && !loop0 && !$past(loop0) && $stable(cts_n[0]) && $stable(dsr_n[0]) && $stable(ri_n[0])
      && $stable(dcd_n[0]) |=> stat_v[0][LINES-1:0] == FLAGS_RST && !primary_irq;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status read left change flags or interrupt pending");

  property p_tx_plain;
    !ir_sel_q |=> secondary_serial_out == $past(sec_uart_tx);
  endproperty
  a_tx_plain: assert property (p_tx_plain)
    else $error("plain transmit data not passed straight through");

  property p_tx_ir;
    ir_sel_q |=> secondary_serial_out == $past(sec_ir_encoded);
  endproperty
  a_tx_ir: assert property (p_tx_ir)
    else $error("infrared data not on secondary transmit pin");

  property p_port_indep;
    wr_ctl0 |=> ##1 $stable(secondary_send_request_n) && $stable(secondary_terminal_ready_n);
  endproperty
  a_port_indep: assert property (p_port_indep)
    else $error("primary control write disturbed secondary pins");

endmodule // umh_top

// *** verif/umh_modem_model.sv ***
`timescale 1ns/10ps
// Far-side modem; slow adds one cycle before a line moves
module umh_modem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Bench control, bit order cts, dsr, ring, carrier
  input wire logic [3:0] line_on,
  input wire logic slow,
  // Handshake lines, active low
  output logic clear_to_transmit_n,
  output logic set_ready_n,
  output logic ring_n,
  output logic carrier_found_n
);
  logic [3:0] stage_q;
  logic [3:0] pin_q;
  // Idle high through reset so release shows no change
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage_q <= 4'hF;
      pin_q <= 4'hF;
    end else begin
      stage_q <= ~line_on;
      pin_q <= slow ? stage_q : ~line_on;
    end
  end
  assign {carrier_found_n, ring_n, set_ready_n, clear_to_transmit_n} = pin_q;
endmodule // umh_modem_model

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import umh_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] rts_n;
  logic [1:0] dtr_n;
  logic [1:0] irq;
  logic [1:0] cts_n;
  logic [1:0] dsr_n;
  logic [1:0] ri_n;
  logic [1:0] dcd_n;
  logic [3:0] line_on [2];
  logic sec_uart_tx = 1'b1;
  logic sec_ir_encoded = 1'b1;
  logic serial_out;
  logic [DATA_W-1:0] rd;
  logic err_seen;
  int n_errors = 0;
  int n_checks = 0;

  always #12.5 clock = ~clock;

  umh_top u_dut (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_send_request_n(rts_n[0]), .primary_terminal_ready_n(dtr_n[0]),
    .primary_clear_to_transmit_n(cts_n[0]), .primary_set_ready_n(dsr_n[0]),
    .primary_ring_n(ri_n[0]), .primary_carrier_found_n(dcd_n[0]), .primary_irq(irq[0]),
    .secondary_send_request_n(rts_n[1]), .secondary_terminal_ready_n(dtr_n[1]),
    .secondary_clear_to_transmit_n(cts_n[1]), .secondary_set_ready_n(dsr_n[1]),
    .secondary_ring_n(ri_n[1]), .secondary_carrier_found_n(dcd_n[1]), .secondary_irq(irq[1]),
    .sec_uart_tx(sec_uart_tx), .sec_ir_encoded(sec_ir_encoded), .secondary_serial_out(serial_out)
  );

  // Secondary modem answers late to vary the input timing
  for (genvar g = 0; g < 2; g++) begin : g_modem
    umh_modem_model u_modem (
      .clock(clock), .rstn(rstn), .line_on(line_on[g]), .slow(1'(g)),
      .clear_to_transmit_n(cts_n[g]), .set_ready_n(dsr_n[g]),
      .ring_n(ri_n[g]), .carrier_found_n(dcd_n[g])
    );
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clock);
    penable <= 1'b1;
    // Waits as long as the slave asks; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  function automatic logic [ADDR_W-1:0] reg_at(input int p, input logic [ADDR_W-1:0] off);
    return off + ((p == 1) ? PORT_STRIDE : 8'h00);
  endfunction

  task final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    final_report;
  end

  initial begin
    line_on[0] = 4'h0;
    line_on[1] = 4'h0;
    repeat (4) @(posedge clock);
    check({30'h0, rts_n}, 32'h3);
    check({30'h0, dtr_n}, 32'h3);
    rstn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int v = 3; v >= 0; v--) begin
        apb(1'b1, reg_at(p, ADDR_CTL0), 32'(v));
        tick(2);
        check({30'h0, rts_n[p], dtr_n[p]}, 32'(~v & 3));
        check({30'h0, rts_n[1-p], dtr_n[1-p]}, 32'h3);
      end
      apb(1'b1, reg_at(p, ADDR_CTL0), 32'h13);
      tick(2);
      check({30'h0, rts_n[p], dtr_n[p]}, 32'h3);
      apb(1'b1, reg_at(p, ADDR_CTL0), 32'h0);
      tick(3);
      apb(1'b0, reg_at(p, ADDR_STAT0), 32'h0);
      apb(1'b1, reg_at(p, ADDR_IER0), 32'h8);
      for (int i = 0; i < 4; i++) begin
        line_on[p][i] <= 1'b1;
        tick(5);
        check({31'h0, irq[p]}, 32'h1);
        check({31'h0, irq[1-p]}, 32'h0);
        apb(1'b1, reg_at(p, ADDR_IER0), 32'h0);
        tick(1);
        check({31'h0, irq[p]}, 32'h0);
        apb(1'b1, reg_at(p, ADDR_IER0), 32'h8);
        apb(1'b0, reg_at(p, ADDR_STAT0), 32'h0);
        check(rd, 32'(1 << (4 + i)));
        tick(1);
        check({31'h0, irq[p]}, 32'h0);
        line_on[p][i] <= 1'b0;
        tick(5);
        check({31'h0, irq[p]}, 32'h1);
        apb(1'b0, reg_at(p, ADDR_STAT0), 32'h0);
        check(rd, 32'(1 << i));
        apb(1'b0, reg_at(p, ADDR_STAT0), 32'h0);
        check(rd, 32'h0);
      end
      apb(1'b1, reg_at(p, ADDR_IER0), 32'h0);
    end
    // Clear-to-transmit toggled alongside data to show it never gates the pin
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, ADDR_FUNC, 32'(f));
      for (int v = 0; v < 2; v++) begin
        sec_uart_tx <= v[0];
        sec_ir_encoded <= ~v[0];
        line_on[1] <= {3'b000, v[0]};
        tick(3);
        check({31'h0, serial_out}, 32'((f ^ v) & 1));
      end
    end
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, err_seen}, 32'h1);
    check(rd, 32'h0);
    check({31'h0, pready}, 32'h1);
    apb(1'b1, ADDR_STAT0, 32'hFF);
    apb(1'b0, ADDR_STAT0, 32'h0);
    check(rd, 32'h0);
    final_report;
  end
endmodule // tb_top
